// >>> wdt_pkg.sv
// Shared constants, field layout and helpers for the watchdog block
package wdt_pkg;

  // ****************************************************************
  // Device register map and codes
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR    = 8'h34;
  localparam logic [7:0] CODE_ADDR    = 8'h35;
  localparam logic [7:0] CLEAR_CODE   = 8'h4E;
  localparam logic [7:0] DISABLE_CODE = 8'hB1;
  localparam logic [7:0] CTRL_RESET   = 8'h09;
  localparam int         EN_BIT       = 3;
  localparam int         DTS_LSB      = 1;
  localparam int         OUT_BIT      = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CORE_HZ         = 40_000_000;
  localparam int FC_HZ           = 40_000_000;
  localparam int RST_MAX_PERIODS = 24;
  localparam int RST_CYCLES      = RST_MAX_PERIODS * CORE_HZ / FC_HZ;
  localparam int TOP_EXP         = 25;
  localparam int STEP_EXP        = 2;
  localparam int QUARTER_EXP     = 2;
  localparam logic [1:0] BIN_LAST = 2'h3;

  // ****************************************************************
  // Host register map
  // ****************************************************************
  localparam logic [7:0] HOST_CMD   = 8'h00;
  localparam logic [7:0] HOST_STAT  = 8'h04;
  localparam logic [7:0] HOST_CFG   = 8'h08;
  localparam int         TARGET_BIT = 8;
  localparam int         ST_RST_BIT = 0;
  localparam int         ST_IRQ_BIT = 1;
  localparam int         ST_CNT_LSB = 8;
  localparam int         ST_NEST_LSB = 16;
  localparam int         CFG_IDLE   = 0;
  localparam int         CFG_DIV2   = 1;
  localparam int         CFG_IMF    = 2;
  localparam int         CFG_RET    = 3;

  typedef enum logic {
    WDT_RUN = 1'b0,
    WDT_RST = 1'b1
  } wdt_state_t;

  // Mask of divider bits that must all be one for a quarter-period tick
  function automatic logic [31:0] wdt_quarter_mask(input logic [1:0] sel,
                                                   input logic       div2,
                                                   input int         top);
    int e;
    e = top - STEP_EXP * int'(sel) - QUARTER_EXP + int'(div2);
    return (32'h1 << e) - 32'h1;
  endfunction

endpackage

// >>> wdt_link.sv
// Link between the CPU-side controller and the watchdog device
`timescale 1ns/100ps
interface wdt_link #(parameter int NEST_W = 4);
  logic              wr_en;
  logic [7:0]        wr_addr;
  logic [7:0]        wr_data;
  logic              idle;
  logic              div2_opt;
  logic              irq_return;
  logic              wd_reset_req;
  logic              wd_overflow_irq;
  logic [NEST_W-1:0] nest_depth;

  modport dev (input wr_en, wr_addr, wr_data, idle, div2_opt, irq_return,
               output wd_reset_req, wd_overflow_irq, nest_depth);
  modport cpu (output wr_en, wr_addr, wr_data, idle, div2_opt, irq_return,
               input wd_reset_req, wd_overflow_irq, nest_depth);
endinterface

// >>> wdt_prescale.sv
// Free-running prescaler that feeds the watchdog binary counter
`timescale 1ns/100ps
module wdt_prescale
  import wdt_pkg::*;
#(
  parameter int DIV_W = 24,
  parameter int TOP   = TOP_EXP
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       hold,
  input  wire logic [1:0] sel,
  input  wire logic       div2,
  output logic            tick
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
  } wdt_pre_t;

  wdt_pre_t         s;
  wdt_pre_t         next_s;
  logic [DIV_W-1:0] mask;
  logic [31:0]      mask_full;

  // ****************************************************************
  // Divider
  // ****************************************************************
  // Never cleared by software, so a refresh lands anywhere in a quarter
  assign mask_full = wdt_quarter_mask(sel, div2, TOP);
  assign mask      = mask_full[DIV_W-1:0];
  assign tick = ce && !hold && ((s.div & mask) == mask);

  always_comb begin
    next_s = s;
    if (!hold) begin
      next_s.div = s.div + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

// >>> wdt_device.sv
// Watchdog device end: control and code registers, counter, outputs
//
// Chosen here: a write-only register port on the link.
`timescale 1ns/100ps
module wdt_device
  import wdt_pkg::*;
#(
  parameter int DIV_W  = 24,
  parameter int TOP    = TOP_EXP,
  parameter int NEST_W = 4
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic ce,
  wdt_link.dev      link
);

  // ****************************************************************
  // Constants and state layout
  // ****************************************************************
  // Pulse counter runs from zero to RST_CYCLES-1, one step per clock
  localparam int RST_W = $clog2(RST_CYCLES + 1);
  localparam logic [RST_W-1:0] RST_LAST = RST_W'(RST_CYCLES - 1);
  localparam logic [NEST_W-1:0] NEST_ONE = NEST_W'(1);
  localparam logic [NEST_W-1:0] NEST_MAX = '1;

  // Device state in one record; the prescaler keeps its own divider
  typedef struct packed {
    wdt_state_t        st;
    logic              en_bit;
    logic              running;
    logic [1:0]        dts;
    logic              out_sel;
    logic [1:0]        bin_cnt;
    logic [RST_W-1:0]  rst_cnt;
    logic              irq;
    logic [NEST_W-1:0] nest;
  } wdt_dev_t;

  // Also loaded at the end of an internal reset pulse
  localparam wdt_dev_t DEV_INIT = '{
    st:      WDT_RUN,
    en_bit:  CTRL_RESET[EN_BIT],
    running: CTRL_RESET[EN_BIT],
    dts:     CTRL_RESET[DTS_LSB +: 2],
    out_sel: CTRL_RESET[OUT_BIT],
    bin_cnt: '0,
    rst_cnt: '0,
    irq:     1'b0,
    nest:    '0
  };

  // ****************************************************************
  // Decode helper
  // ****************************************************************
  // One write strobe hitting the code register with one exact value
  function automatic logic wdt_code_hit(input logic       wr,
                                        input logic [7:0] addr,
                                        input logic [7:0] data,
                                        input logic [7:0] code);
    return wr && addr == CODE_ADDR && data == code;
  endfunction

  // ****************************************************************
  // State and nets
  // ****************************************************************
  wdt_dev_t s;
  wdt_dev_t next_s;
  logic     tick;
  logic     hold;
  logic     ctrl_wr;
  logic     clear_hit;
  logic     disable_hit;
  logic     overflow;

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // Idle and the reset pulse both freeze the time base
  wdt_prescale #(
    .DIV_W (DIV_W),
    .TOP   (TOP)
  ) u_pre (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .hold     (hold),
    .sel      (s.dts),
    .div2     (link.div2_opt),
    .tick     (tick)
  );

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // No read path exists; the registers only take writes
  assign ctrl_wr  = link.wr_en && link.wr_addr == CTRL_ADDR;
  // Fourth quarter tick with the top count already reached
  assign overflow = s.running && tick && s.bin_cnt == BIN_LAST;
  assign clear_hit   = wdt_code_hit(link.wr_en, link.wr_addr, link.wr_data, CLEAR_CODE);
  assign disable_hit = wdt_code_hit(link.wr_en, link.wr_addr, link.wr_data, DISABLE_CODE);
  // The time base stops in idle and while the internal reset runs
  assign hold        = link.idle || s.st == WDT_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s     = s;
    next_s.irq = 1'b0;
    unique case (s.st)
      // Writes that land during the reset pulse are lost
      WDT_RUN: begin
        if (ctrl_wr) begin
          next_s.en_bit  = link.wr_data[EN_BIT];
          next_s.dts     = link.wr_data[DTS_LSB +: 2];
          // Select can only move from reset request to interrupt
          next_s.out_sel = s.out_sel & link.wr_data[OUT_BIT];
          if (link.wr_data[EN_BIT]) begin
            next_s.running = 1'b1;
          end
        end

        // Any other code value falls through untouched
        if (clear_hit) begin
          next_s.bin_cnt = '0;
        end else if (disable_hit && !s.en_bit) begin
          next_s.running = 1'b0;
        end

        // A refresh in the tick cycle wins: software intent is honoured
        if (s.running && tick && !clear_hit) begin
          if (overflow) begin
            next_s.bin_cnt = '0;
            if (s.out_sel) begin
              next_s.st      = WDT_RST;
              next_s.rst_cnt = '0;
            end else begin
              next_s.irq = 1'b1;
              // Taken at once; earlier levels stay on the nest count
              if (s.nest != NEST_MAX) begin
                next_s.nest = s.nest + NEST_ONE;
              end
            end
          end else begin
            next_s.bin_cnt = s.bin_cnt + 2'h1;
          end
        end

        // A return with nothing pending is dropped; the count saturates
        if (link.irq_return && next_s.nest != '0) begin
          next_s.nest = next_s.nest - NEST_ONE;
        end

        if (!next_s.running) begin
          next_s.bin_cnt = '0;
        end
      end
      WDT_RST: begin
        // Internal reset reinitialises the block, select included
        if (s.rst_cnt == RST_LAST) begin
          next_s = DEV_INIT;
        end else begin
          next_s.rst_cnt = s.rst_cnt + RST_W'(1);
        end
      end
    endcase
  end

  // Clock enable low freezes every field at once
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= DEV_INIT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // All outputs come straight from state flops
  assign link.wd_reset_req    = s.st == WDT_RST;
  assign link.wd_overflow_irq = s.irq;
  assign link.nest_depth      = s.nest;

endmodule

// >>> wdt_host.sv
// CPU-side controller: APB registers that drive the watchdog link
`timescale 1ns/100ps
module wdt_host
  import wdt_pkg::*;
#(
  parameter int NEST_W = 4
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  wdt_link.cpu             link
);

  typedef struct packed {
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        idle;
    logic        div2;
    logic        interrupt_master_flag;
    logic        irq_ret;
    logic        irq_flag;
    logic [7:0]  irq_count;
    logic [31:0] prdata;
  } wdt_host_t;

  wdt_host_t s;
  wdt_host_t next_s;
  logic      mapped;
  logic      access;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign mapped  = paddr == HOST_CMD || paddr == HOST_STAT || paddr == HOST_CFG;
  assign access  = psel && penable && ce;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s.prdata;

  always_comb begin
    next_s         = s;
    next_s.wr_en   = 1'b0;
    next_s.irq_ret = 1'b0;
    // Read data is staged in the setup cycle so it comes from a flop
    if (psel && !penable) begin
      next_s.prdata = '0;
      if (paddr == HOST_STAT) begin
        next_s.prdata[ST_RST_BIT]            = link.wd_reset_req;
        next_s.prdata[ST_IRQ_BIT]            = s.irq_flag;
        next_s.prdata[ST_CNT_LSB +: 8]       = s.irq_count;
        next_s.prdata[ST_NEST_LSB +: NEST_W] = link.nest_depth;
      end else if (paddr == HOST_CFG) begin
        next_s.prdata[CFG_IDLE] = s.idle;
        next_s.prdata[CFG_DIV2] = s.div2;
        next_s.prdata[CFG_IMF]  = s.interrupt_master_flag;
      end
    end
    if (access && pwrite && paddr == HOST_CMD) begin
      // Refresh cadence and ordering are the software's job
      next_s.wr_en   = 1'b1;
      next_s.wr_addr = pwdata[TARGET_BIT] ? CODE_ADDR : CTRL_ADDR;
      next_s.wr_data = pwdata[7:0];
    end
    if (access && pwrite && paddr == HOST_CFG) begin
      next_s.idle    = pwdata[CFG_IDLE];
      next_s.div2    = pwdata[CFG_DIV2];
      next_s.interrupt_master_flag     = pwdata[CFG_IMF];
      next_s.irq_ret = pwdata[CFG_RET];
    end
    if (access && pwrite && paddr == HOST_STAT && pwdata[ST_IRQ_BIT]) begin
      next_s.irq_flag = 1'b0;
    end
    // Accepted whatever the master flag says; set beats clear
    if (link.wd_overflow_irq) begin
      next_s.irq_flag  = 1'b1;
      next_s.irq_count = s.irq_count + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Link drive
  // ****************************************************************
  assign link.wr_en      = s.wr_en;
  assign link.wr_addr    = s.wr_addr;
  assign link.wr_data    = s.wr_data;
  assign link.idle       = s.idle;
  assign link.div2_opt   = s.div2;
  assign link.irq_return = s.irq_ret;

endmodule

// >>> wdt_link_props.sv
// Concurrent checks on the link between the controller and the watchdog device
`timescale 1ns/100ps
module wdt_link_props
  import wdt_pkg::*;
#(
  parameter int TOP    = TOP_EXP,
  parameter int NEST_W = 4
) (
  input wire logic              core_clk,
  input wire logic              resetn,
  input wire logic              wr_en,
  input wire logic [7:0]        wr_addr,
  input wire logic [7:0]        wr_data,
  input wire logic              idle,
  input wire logic              div2_opt,
  input wire logic              irq_return,
  input wire logic              wd_reset_req,
  input wire logic              wd_overflow_irq,
  input wire logic [NEST_W-1:0] nest_depth
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [4:0]  rst_cnt;
  logic [15:0] clr_age;
  logic [1:0]  sel_q;
  logic [15:0] min_age;
  logic        taken;

  assign taken = wr_en && !wd_reset_req;
  // Lower bound only: the divider phase at a clear is not visible here
  assign min_age = 16'h3 << (TOP - QUARTER_EXP - STEP_EXP * sel_q + div2_opt);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt <= 5'h0;
      clr_age <= 16'h0;
      sel_q   <= 2'h0;
    end else begin
      rst_cnt <= wd_reset_req ? rst_cnt + 5'h1 : 5'h0;
      if (taken && wr_addr == CODE_ADDR && wr_data == CLEAR_CODE) begin
        clr_age <= 16'h0;
      end else if (clr_age != 16'hFFFF) begin
        clr_age <= clr_age + 16'h1;
      end
      if (taken && wr_addr == CTRL_ADDR) begin
        sel_q <= wr_data[2:1];
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rst_max;
    wd_reset_req |-> rst_cnt < 5'h18;
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("reset request too long");
  property p_rst_len;
    $fell(wd_reset_req) |-> $past(rst_cnt) == RST_CYCLES - 1;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset request length");
  property p_irq_pulse;
    wd_overflow_irq |=> !wd_overflow_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  property p_excl;
    wd_reset_req |-> !wd_overflow_irq;
  endproperty
  a_excl: assert property (p_excl) else $error("irq during reset request");
  property p_min_time;
    (wd_overflow_irq || $rose(wd_reset_req)) |-> clr_age >= min_age;
  endproperty
  a_min_time: assert property (p_min_time) else $error("overflow too soon");
  property p_idle;
    idle && $past(idle) && $past(idle, 2) |-> !wd_overflow_irq && !$rose(wd_reset_req);
  endproperty
  a_idle: assert property (p_idle) else $error("overflow while idle");
  property p_nest_up;
    wd_overflow_irq && !$past(irq_return) && $past(nest_depth) != {NEST_W{1'b1}}
      |-> nest_depth == $past(nest_depth) + 1'b1;
  endproperty
  a_nest_up: assert property (p_nest_up) else $error("nest not raised");
  property p_nest_down;
    irq_return && nest_depth != '0
      |=> wd_overflow_irq || nest_depth == $past(nest_depth) - 1'b1;
  endproperty
  a_nest_down: assert property (p_nest_down) else $error("nest not lowered");
  property p_nest_hold;
    !irq_return && !wd_reset_req |=> wd_overflow_irq || $stable(nest_depth);
  endproperty
  a_nest_hold: assert property (p_nest_hold) else $error("nest moved");
endmodule

// >>> wdt_tb.sv
// Self-checking bench: APB controller joined to the watchdog device
`timescale 1ns/100ps
module testbench
  import wdt_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int TOP_T = 9;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        ce       = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          evt          = 0;
  int          n;
  int          mn;
  int          mx;

  wdt_link #(.NEST_W(4)) link ();
  wdt_device #(.DIV_W(8), .TOP(TOP_T), .NEST_W(4)) u_wdt_device (.core_clk(core_clk),
    .resetn(resetn), .ce(ce), .link(link));
  wdt_host #(.NEST_W(4)) u_wdt_host (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  wdt_link_props #(.TOP(TOP_T), .NEST_W(4)) u_wdt_link_props (.core_clk(core_clk),
    .resetn(resetn), .wr_en(link.wr_en), .wr_addr(link.wr_addr), .wr_data(link.wr_data),
    .idle(link.idle), .div2_opt(link.div2_opt), .irq_return(link.irq_return),
    .wd_reset_req(link.wd_reset_req), .wd_overflow_irq(link.wd_overflow_irq),
    .nest_depth(link.nest_depth));

  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (link.wd_overflow_irq === 1'b1 || link.wd_reset_req === 1'b1) begin
      evt++;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Whole-word writes only; no read-modify-write of device registers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic dwr(input logic code, input logic [7:0] d);
    apb(1'b1, HOST_CMD, {23'h0, code, d});
  endtask

  task automatic wait_out(input int lim);
    n = 0;
    while (n < lim && link.wd_overflow_irq !== 1'b1 && link.wd_reset_req !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  function automatic int qtr(input int s, input int d);
    return 1 << (TOP_T - 2 - 2 * s + d);
  endfunction

  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, HOST_STAT, 32'h0);
    chk(rd, 32'h0);
    wait_out(700);
    chk(link.wd_reset_req, 1'b1);
    chk(n >= 3 * qtr(0, 0) && n <= 4 * qtr(0, 0) + 4, 1'b1);
    n = 0;
    while (link.wd_reset_req === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(n, RST_CYCLES);
    // Clear around each detection time change
    // All clears come from the main flow, none from an interrupt handler
    dwr(1'b1, CLEAR_CODE);
    dwr(1'b0, 8'h0D);
    dwr(1'b1, CLEAR_CODE);
    evt = 0;
    repeat (15) begin
      repeat (8) @(posedge core_clk);
      dwr(1'b1, CLEAR_CODE);
    end
    chk(evt, 0);
    wait_out(60);
    chk(link.wd_reset_req, 1'b1);
    repeat (30) @(posedge core_clk);
    apb(1'b1, HOST_CFG, 32'h0);
    dwr(1'b1, CLEAR_CODE);
    dwr(1'b0, 8'h0C);
    dwr(1'b1, CLEAR_CODE);
    mn = 9999;
    mx = 0;
    // Clears at every divider phase expose a divider that is wrongly cleared
    for (int ph = 0; ph < 8; ph++) begin
      repeat (ph) @(posedge core_clk);
      dwr(1'b1, CLEAR_CODE);
      wait_out(60);
      chk(link.wd_overflow_irq, 1'b1);
      mn = (n < mn) ? n : mn;
      mx = (n > mx) ? n : mx;
    end
    chk(mx - mn >= 4, 1'b1);
    chk(mn >= 3 * qtr(2, 0) && mx <= 4 * qtr(2, 0) + 4, 1'b1);
    dwr(1'b1, CLEAR_CODE);
    dwr(1'b0, 8'h08);
    dwr(1'b1, CLEAR_CODE);
    apb(1'b0, HOST_STAT, 32'h0);
    chk(rd[19:0], 20'h80802);
    apb(1'b1, HOST_STAT, 32'h2);
    apb(1'b0, HOST_STAT, 32'h0);
    chk(rd[1], 1'b0);
    repeat (8) apb(1'b1, HOST_CFG, 32'h8);
    apb(1'b0, HOST_STAT, 32'h0);
    chk(rd[19:16], 4'h0);
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 2; d++) begin
        apb(1'b1, HOST_CFG, {30'h0, d[0], 1'b0});
        dwr(1'b1, CLEAR_CODE);
        dwr(1'b0, {5'h01, s[1:0], 1'b1});
        dwr(1'b1, CLEAR_CODE);
        wait_out(1200);
        chk(link.wd_overflow_irq, 1'b1);
        chk(n >= 3 * qtr(s, d) && n <= 4 * qtr(s, d) + 4, 1'b1);
        apb(1'b1, HOST_CFG, {28'h0, 1'b1, 1'b0, d[0], 1'b0});
      end
    end
    dwr(1'b1, CLEAR_CODE);
    dwr(1'b0, 8'h0C);
    dwr(1'b1, CLEAR_CODE);
    apb(1'b1, HOST_CFG, 32'h1);
    apb(1'b0, HOST_CFG, 32'h0);
    chk(rd, 32'h1);
    evt = 0;
    repeat (200) @(posedge core_clk);
    chk(evt, 0);
    apb(1'b1, HOST_CFG, 32'h0);
    wait_out(80);
    chk(link.wd_overflow_irq, 1'b1);
    dwr(1'b1, CLEAR_CODE);
    evt = 0;
    for (int i = 0; i < 16; i++) begin
      dwr(1'b1, i[0] ? DISABLE_CODE : 8'h5A);
    end
    chk(evt > 0, 1'b1);
    // Clear first so the disable never lands near an overflow
    apb(1'b1, HOST_CFG, 32'h0);
    dwr(1'b1, CLEAR_CODE);
    dwr(1'b0, 8'h04);
    dwr(1'b1, DISABLE_CODE);
    evt = 0;
    repeat (300) @(posedge core_clk);
    chk(evt, 0);
    dwr(1'b0, 8'h0C);
    wait_out(60);
    chk(link.wd_overflow_irq, 1'b1);
    chk(n >= 3 * qtr(2, 0), 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, HOST_STAT, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
